// file: src/ssl_top.sv
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
module ssl_top
  import ssl_pkg::*;
#(
  parameter int SLOW_CYCLES = SLOW_DELAY_CYC
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Comparator trip levels from the analog supervisors and monitors.
  input wire logic low_sup_trip,
  input wire logic low_mon_trip,
  input wire logic high_sup_trip,
  input wire logic high_mon_trip,
  // CPU side sleep and wake events.
  input wire logic wake_irq,
  input wire logic isr_return,
  // Return-to-normal sources.
  input wire logic power_up_clear,
  input wire logic ext_reset_n,
  // Power state outputs.
  output logic [1:0] power_mode,
  output logic cpu_hold,
  output logic wake_fast,
  output logic [1:0] low_sup_state,
  output logic [1:0] low_mon_state,
  output logic [1:0] high_sup_state,
  output logic [1:0] high_mon_state,
  output logic low_side_settle_flag,
  output logic high_side_settle_flag,
  // Reset request and interrupt.
  output logic por_req,
  output logic irq
);

  localparam logic [TIMER_W-1:0] SLOW_LOAD = SLOW_CYCLES[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] FAST_LOAD = FAST_DELAY_CYC[TIMER_W-1:0];

  // Decodes one unit's performance state from its settings.
  function automatic ssl_perf_t perf_of(input logic en, input logic keep,
                                        input logic fp, input logic auto_c,
                                        input logic deep);
    ssl_perf_t r;
    r = PERF_OFF;
    if (en && (!deep || keep))
    begin
      if (deep && auto_c)
      begin
        r = fp ? PERF_NORMAL : PERF_OFF;
      end
      else
      begin
        r = fp ? PERF_FULL : PERF_NORMAL;
      end
    end
    return r;
  endfunction

  // Bus and register state.
  logic aw_full_ff;
  logic [7:0] awaddr_ff;
  logic w_full_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [LOW_CTRL_W-1:0] low_side_control_reg_ff;
  logic [HIGH_CTRL_W-1:0] high_side_control_reg_ff;
  logic cfg_low_por_ff;
  logic sleep_on_exit_ff;
  logic exit_deep_ff;
  logic [FLAG_W-1:0] power_flag_reg_ff;
  logic [FLAG_W-1:0] mask_ff;
  ssl_mode_t mode_ff;
  ssl_mode_t nxt_mode;
  logic por_req_ff;
  logic [1:0] low_sup_ff;
  logic [1:0] low_mon_ff;
  logic [1:0] high_sup_ff;
  logic [1:0] high_mon_ff;
  logic wake_fast_ff;

  // Bus handshakes and write decode.
  logic do_write;
  logic wr_en;
  logic wr_low;
  logic wr_high;
  logic wr_cfg;
  logic wr_lpm;
  logic wr_flags;
  logic wr_mask;
  logic wr_hit;
  logic ar_take;
  assign s_axi_awready = !aw_full_ff && !bvalid_ff;
  assign s_axi_wready = !w_full_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
  assign wr_en = do_write && wstrb0_ff;
  assign wr_low = wr_en && (awaddr_ff == OFF_LOW_CTRL);
  assign wr_high = wr_en && (awaddr_ff == OFF_HIGH_CTRL);
  assign wr_cfg = wr_en && (awaddr_ff == OFF_CONFIG);
  assign wr_lpm = wr_en && (awaddr_ff == OFF_LPM);
  assign wr_flags = wr_en && (awaddr_ff == OFF_FLAGS);
  assign wr_mask = wr_en && (awaddr_ff == OFF_MASK);
  assign wr_hit = (awaddr_ff == OFF_LOW_CTRL) ||
                  (awaddr_ff == OFF_HIGH_CTRL) ||
                  (awaddr_ff == OFF_CONFIG) || (awaddr_ff == OFF_LPM) ||
                  (awaddr_ff == OFF_STATUS) || (awaddr_ff == OFF_FLAGS) ||
                  (awaddr_ff == OFF_MASK);
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // Control fields pulled apart for readability.
  logic l_sup_en, l_sup_md, l_sup_fp, l_mon_en, l_mon_fp, l_auto;
  logic h_sup_en, h_sup_md, h_sup_fp, h_mon_en, h_mon_fp, h_auto, h_ovp;
  assign l_sup_en = low_side_control_reg_ff[SUP_EN];
  assign l_sup_md = low_side_control_reg_ff[SUP_MODE];
  assign l_sup_fp = low_side_control_reg_ff[SUP_FP];
  assign l_mon_en = low_side_control_reg_ff[MON_EN];
  assign l_mon_fp = low_side_control_reg_ff[MON_FP];
  assign l_auto = low_side_control_reg_ff[AUTO_CTL];
  assign h_sup_en = high_side_control_reg_ff[SUP_EN];
  assign h_sup_md = high_side_control_reg_ff[SUP_MODE];
  assign h_sup_fp = high_side_control_reg_ff[SUP_FP];
  assign h_mon_en = high_side_control_reg_ff[MON_EN];
  assign h_mon_fp = high_side_control_reg_ff[MON_FP];
  assign h_auto = high_side_control_reg_ff[AUTO_CTL];
  assign h_ovp = high_side_control_reg_ff[OVP_EN];

  // Unit states follow the power mode; waking units count as active.
  logic deep;
  ssl_perf_t ls_nxt, lm_nxt, hs_nxt, hm_nxt;
  assign deep = (mode_ff == PM_DEEP);
  assign ls_nxt = perf_of(l_sup_en, l_sup_md, l_sup_fp, l_auto, deep);
  assign lm_nxt = perf_of(l_mon_en, 1'b1, l_mon_fp, l_auto, deep);
  assign hs_nxt = perf_of(h_sup_en, h_sup_md, h_sup_fp, h_auto, deep);
  assign hm_nxt = (deep && h_auto) ? PERF_OFF :
                  perf_of(h_mon_en, 1'b1, h_mon_fp, 1'b0, deep);

  logic nxt_wake_fast;
  assign nxt_wake_fast = !((l_sup_en && !l_sup_fp) ||
                           (l_mon_en && !l_mon_fp));

  logic [TIMER_W-1:0] low_settle_load;
  logic [TIMER_W-1:0] high_settle_load;
  logic [TIMER_W-1:0] wake_load;
  assign low_settle_load = wdata_ff[SUP_FP] ? FAST_LOAD : SLOW_LOAD;
  assign high_settle_load = wdata_ff[SUP_FP] ? FAST_LOAD : SLOW_LOAD;
  assign wake_load = wake_fast_ff ? FAST_LOAD : SLOW_LOAD;

  ssl_timer #(.W(TIMER_W)) u_low_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wr_low),
    .load(low_settle_load),
    .busy(low_side_settle_flag)
  );

  ssl_timer #(.W(TIMER_W)) u_high_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wr_high),
    .load(high_settle_load),
    .busy(high_side_settle_flag)
  );

  logic wake_start;
  logic wake_busy;
  assign wake_start = (mode_ff == PM_DEEP) && wake_irq;
  ssl_timer #(.W(TIMER_W)) u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wake_start),
    .load(wake_load),
    .busy(wake_busy)
  );

  logic deep_req;
  logic light_req;
  logic clear_req;
  assign deep_req = (wr_lpm && wdata_ff[LPM_DEEP_REQ]) ||
                    (isr_return && sleep_on_exit_ff && exit_deep_ff);
  assign light_req = (wr_lpm && wdata_ff[LPM_LIGHT_REQ]) ||
                     (isr_return && sleep_on_exit_ff && !exit_deep_ff);
  assign clear_req = power_up_clear || !ext_reset_n;

  // Mode sequencer; a deep request outranks a light one.
  always_comb
  begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      PM_ACTIVE:
      begin
        if (deep_req)
        begin
          nxt_mode = PM_DEEP;
        end
        else if (light_req)
        begin
          nxt_mode = PM_LIGHT;
        end
      end
      PM_LIGHT:
      begin
        if (wake_irq)
        begin
          nxt_mode = PM_ACTIVE;
        end
      end
      PM_DEEP:
      begin
        if (wake_irq)
        begin
          nxt_mode = PM_WAKE;
        end
      end
      PM_WAKE:
      begin
        if (!wake_busy)
        begin
          nxt_mode = PM_ACTIVE;
        end
      end
    endcase
    if (clear_req)
    begin
      nxt_mode = PM_ACTIVE;
    end
  end

  // Trips count only while the unit is on.
  logic low_evt;
  logic low_sup_evt;
  logic low_mon_evt;
  logic high_sup_evt;
  logic high_mon_evt;
  logic ovp_evt;
  logic nxt_por;
  logic [FLAG_W-1:0] flag_set;
  assign low_sup_evt = low_sup_trip && (low_sup_ff != PERF_OFF);
  assign low_mon_evt = low_mon_trip && (low_mon_ff != PERF_OFF);
  assign high_sup_evt = high_sup_trip && (high_sup_ff != PERF_OFF);
  assign high_mon_evt = high_mon_trip && (high_mon_ff != PERF_OFF);
  assign low_evt = low_sup_evt || low_mon_evt;
  assign ovp_evt = high_mon_evt && h_ovp;
  assign nxt_por = (low_evt && cfg_low_por_ff) || ovp_evt;
  assign flag_set = {(mode_ff == PM_WAKE) && !wake_busy,
                     high_mon_evt && !h_ovp,
                     high_sup_evt,
                     low_mon_evt && !cfg_low_por_ff,
                     low_sup_evt && !cfg_low_por_ff};

  // Sticky flags: a new event wins over a same-cycle write of one.
  logic [FLAG_W-1:0] nxt_flags;
  assign nxt_flags = flag_set |
    (power_flag_reg_ff & ~(wr_flags ? wdata_ff[FLAG_W-1:0] : '0));

  // Read mux; unmapped offsets read zero with an error response.
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic rd_hit;
  assign status_word = {18'h0, mode_ff != PM_ACTIVE, wake_fast_ff,
                        high_side_settle_flag, low_side_settle_flag,
                        high_mon_ff, high_sup_ff, low_mon_ff, low_sup_ff,
                        mode_ff};
  assign rd_hit = (s_axi_araddr == OFF_LOW_CTRL) ||
                  (s_axi_araddr == OFF_HIGH_CTRL) ||
                  (s_axi_araddr == OFF_CONFIG) ||
                  (s_axi_araddr == OFF_LPM) ||
                  (s_axi_araddr == OFF_STATUS) ||
                  (s_axi_araddr == OFF_FLAGS) ||
                  (s_axi_araddr == OFF_MASK);
  assign rd_word =
    (s_axi_araddr == OFF_LOW_CTRL) ? {26'h0, low_side_control_reg_ff} :
    (s_axi_araddr == OFF_HIGH_CTRL) ? {25'h0, high_side_control_reg_ff} :
    (s_axi_araddr == OFF_CONFIG) ? {31'h0, cfg_low_por_ff} :
    (s_axi_araddr == OFF_LPM) ? {28'h0, exit_deep_ff, sleep_on_exit_ff,
                                 2'h0} :
    (s_axi_araddr == OFF_STATUS) ? status_word :
    (s_axi_araddr == OFF_FLAGS) ? {27'h0, power_flag_reg_ff} :
    (s_axi_araddr == OFF_MASK) ? {27'h0, mask_ff} : 32'h0;

  // Write address and data holding; either may arrive first.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      w_full_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      else if (do_write)
      begin
        aw_full_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
      else if (do_write)
      begin
        w_full_ff <= 1'b0;
      end
    end
  end

  // Write and read responses.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
      if (ar_take)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Software-written registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_side_control_reg_ff <= LOW_CTRL_RST;
      high_side_control_reg_ff <= HIGH_CTRL_RST;
      cfg_low_por_ff <= 1'b0;
      sleep_on_exit_ff <= 1'b0;
      exit_deep_ff <= 1'b0;
      mask_ff <= '0;
    end
    else
    begin
      if (wr_low)
      begin
        low_side_control_reg_ff <= wdata_ff[LOW_CTRL_W-1:0];
      end
      if (wr_high)
      begin
        high_side_control_reg_ff <= wdata_ff[HIGH_CTRL_W-1:0];
      end
      if (wr_cfg)
      begin
        cfg_low_por_ff <= wdata_ff[CFG_LOW_POR];
      end
      if (wr_lpm)
      begin
        sleep_on_exit_ff <= wdata_ff[LPM_ON_EXIT];
        exit_deep_ff <= wdata_ff[LPM_EXIT_DEEP];
      end
      if (wr_mask)
      begin
        mask_ff <= wdata_ff[FLAG_W-1:0];
      end
    end
  end

  // Mode, unit states, flags and reset request.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_ff <= PM_ACTIVE;
      low_sup_ff <= PERF_OFF;
      low_mon_ff <= PERF_OFF;
      high_sup_ff <= PERF_OFF;
      high_mon_ff <= PERF_OFF;
      wake_fast_ff <= 1'b0;
      power_flag_reg_ff <= '0;
      por_req_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      low_sup_ff <= ls_nxt;
      low_mon_ff <= lm_nxt;
      high_sup_ff <= hs_nxt;
      high_mon_ff <= hm_nxt;
      wake_fast_ff <= nxt_wake_fast;
      power_flag_reg_ff <= nxt_flags;
      por_req_ff <= nxt_por;
    end
  end

  // Outputs.
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign power_mode = mode_ff;
  assign cpu_hold = (mode_ff != PM_ACTIVE);
  assign wake_fast = wake_fast_ff;
  assign low_sup_state = low_sup_ff;
  assign low_mon_state = low_mon_ff;
  assign high_sup_state = high_sup_ff;
  assign high_mon_state = high_mon_ff;
  assign por_req = por_req_ff;
  // The interrupt is a level, so it drops as soon as software clears.
  assign irq = |(power_flag_reg_ff & mask_ff);

endmodule

// file: src/ssl_pkg.sv
package ssl_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFF_LOW_CTRL = 8'h00;
  localparam logic [7:0] OFF_HIGH_CTRL = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;
  localparam logic [7:0] OFF_LPM = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;

  // Field positions of both side control registers; OVP_EN is on the high side only.
  localparam int SUP_EN = 0;
  localparam int SUP_MODE = 1;
  localparam int SUP_FP = 2;
  localparam int MON_EN = 3;
  localparam int MON_FP = 4;
  localparam int AUTO_CTL = 5;
  localparam int OVP_EN = 6;
  localparam int LOW_CTRL_W = 6;
  localparam int HIGH_CTRL_W = 7;

  // Field positions of the configuration and sleep request registers.
  localparam int CFG_LOW_POR = 0;
  localparam int LPM_DEEP_REQ = 0;
  localparam int LPM_LIGHT_REQ = 1;
  localparam int LPM_ON_EXIT = 2;
  localparam int LPM_EXIT_DEEP = 3;

  // Sticky event flags, shared layout with the mask register.
  localparam int FLG_LOW_SUP = 0;
  localparam int FLG_LOW_MON = 1;
  localparam int FLG_HIGH_SUP = 2;
  localparam int FLG_HIGH_MON = 3;
  localparam int FLG_WAKE = 4;
  localparam int FLAG_W = 5;

  // Status register field positions.
  localparam int ST_MODE = 0;
  localparam int ST_LOW_SUP = 2;
  localparam int ST_LOW_MON = 4;
  localparam int ST_HIGH_SUP = 6;
  localparam int ST_HIGH_MON = 8;
  localparam int ST_LOW_SETTLE = 10;
  localparam int ST_HIGH_SETTLE = 11;
  localparam int ST_WAKE_FAST = 12;
  localparam int ST_CPU_HOLD = 13;

  // Reset values: both supervisors and monitors enabled, normal mode.
  localparam logic [LOW_CTRL_W-1:0] LOW_CTRL_RST = 6'h09;
  localparam logic [HIGH_CTRL_W-1:0] HIGH_CTRL_RST = 7'h09;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Delay times and their cycle counts at the 8 ns clock.
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SLOW_DELAY_NS = 150000;
  localparam int unsigned FAST_DELAY_NS = 2000;
  localparam int unsigned SLOW_DELAY_CYC =
    (SLOW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FAST_DELAY_CYC =
    (FAST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  typedef enum logic [1:0] {
    PERF_OFF = 2'b00,
    PERF_NORMAL = 2'b01,
    PERF_FULL = 2'b10
  } ssl_perf_t;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_LIGHT = 2'b01,
    PM_DEEP = 2'b10,
    PM_WAKE = 2'b11
  } ssl_mode_t;

endpackage

// file: src/ssl_timer.sv
`timescale 1ns/100ps
module ssl_timer
  import ssl_pkg::*;
#(
  parameter int W = TIMER_W
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Start and length.
  input wire logic start,
  input wire logic [W-1:0] load,
  // Running indication.
  output logic busy
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // A new start restarts the count from the new load, so a rewrite restarts the delay.
  assign nxt_cnt = start ? load :
                   (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;

  // Busy covers the start cycle so no gap shows before the count.
  assign busy = start | (cnt_ff != '0);

  // Down counter.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= '0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// file: tb/ssl_chk_asserts.sv
`timescale 1ns/100ps
module ssl_chk_asserts
  import ssl_pkg::*;
#(
  parameter int SLOW_CYCLES = SLOW_DELAY_CYC
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write path.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  // Sleep control and unit state.
  input wire logic wake_irq,
  input wire logic power_up_clear,
  input wire logic ext_reset_n,
  input wire logic [1:0] power_mode,
  input wire logic cpu_hold,
  input wire logic wake_fast,
  input wire logic [1:0] low_sup_state,
  input wire logic [1:0] low_mon_state,
  input wire logic low_side_settle_flag,
  // Events.
  input wire logic low_sup_trip,
  input wire logic low_mon_trip,
  input wire logic high_sup_trip,
  input wire logic high_mon_trip,
  input wire logic por_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] aw_q_ff;
  logic [15:0] set_cnt_ff, wk_cnt_ff;
  logic clr;
  localparam int SET_MAX =
    (SLOW_CYCLES > FAST_DELAY_CYC) ? SLOW_CYCLES : FAST_DELAY_CYC;
  // Either clear source forces the active mode.
  assign clr = power_up_clear || !ext_reset_n;
  // Run lengths are counted so long waits need no long repetition.
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_q_ff <= s_axi_awaddr;
    set_cnt_ff <= low_side_settle_flag ? set_cnt_ff + 16'h1 : 16'h0;
    wk_cnt_ff <= (power_mode == PM_WAKE) ? wk_cnt_ff + 16'h1 : 16'h0;
  end
  sequence s_deep_irq;
    power_mode == PM_DEEP && wake_irq && !clr;
  endsequence
  sequence s_low_write;
    $rose(s_axi_bvalid) && aw_q_ff == OFF_LOW_CTRL && s_axi_bresp == RESP_OKAY;
  endsequence
  sequence s_steady;
    ($stable(low_sup_state) && $stable(low_mon_state)
      && power_mode == PM_ACTIVE) [*3];
  endsequence
  a_hold_mode: assert property (cpu_hold == (power_mode != PM_ACTIVE))
    else $error("cpu hold disagrees with mode");
  a_deep_wake: assert property (s_deep_irq |=> power_mode == PM_WAKE)
    else $error("deep sleep ignored interrupt");
  a_light_wake: assert property (power_mode == PM_LIGHT && wake_irq
    && !clr |=> power_mode == PM_ACTIVE)
    else $error("light sleep ignored interrupt");
  a_clear_mode: assert property (clr |=> power_mode == PM_ACTIVE)
    else $error("clear did not return to active");
  a_settle_set: assert property (s_low_write |-> low_side_settle_flag)
    else $error("settle flag not set by write");
  a_settle_len: assert property (set_cnt_ff <= SET_MAX + 2)
    else $error("settle flag held too long");
  a_wake_len: assert property ($fell(power_mode == PM_WAKE)
    && !$past(clr) |-> wk_cnt_ff >= (wake_fast ? 248 : SLOW_CYCLES - 2)
    && wk_cnt_ff <= (wake_fast ? 252 : SLOW_CYCLES + 2))
    else $error("wake time off");
  a_wake_speed: assert property (s_steady |-> wake_fast ==
    !(low_sup_state == PERF_NORMAL || low_mon_state == PERF_NORMAL))
    else $error("wake speed wrong for unit states");
  a_por_cause: assert property (por_req |-> $past(low_sup_trip
    || low_mon_trip || high_sup_trip || high_mon_trip))
    else $error("reset request without trip");
endmodule
bind ssl_top ssl_chk_asserts #(.SLOW_CYCLES(SLOW_CYCLES)) chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
  .s_axi_bvalid, .s_axi_bresp, .wake_irq, .power_up_clear, .ext_reset_n,
  .power_mode, .cpu_hold, .wake_fast, .low_sup_state, .low_mon_state,
  .low_side_settle_flag, .low_sup_trip, .low_mon_trip, .high_sup_trip,
  .high_mon_trip, .por_req
);

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench
  import ssl_pkg::*;
;
  localparam int SLOW = 40;
  // Bench side of the design ports.
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, wake_irq, isr_return;
  logic power_up_clear, ext_reset_n;
  logic low_sup_trip, low_mon_trip, high_sup_trip, high_mon_trip;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q, power_mode;
  logic [1:0] low_sup_state, low_mon_state, high_sup_state, high_mon_state;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_hold, wake_fast, por_req, irq;
  logic low_side_settle_flag, high_side_settle_flag;
  logic [6:0] lc, hc;
  int num_errors, samples_checked, cyc, pc, n, e;
  // Short slow delay keeps the run small; expectations use it.
  ssl_top #(.SLOW_CYCLES(SLOW)) dut_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .low_sup_trip, .low_mon_trip, .high_sup_trip, .high_mon_trip,
    .wake_irq, .isr_return, .power_up_clear, .ext_reset_n, .power_mode,
    .cpu_hold, .wake_fast, .low_sup_state, .low_mon_state, .high_sup_state,
    .high_mon_state, .low_side_settle_flag, .high_side_settle_flag,
    .por_req, .irq
  );
  // Free running clock.
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Verdict in one place.
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, well above the length of the full sequence.
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // Handshakes are seen at the falling edge and acted on at the next rise.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      resp_q = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tb;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp_q = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  // Length of a settle flag after a control write, within a small margin.
  task automatic settle(input logic hi, input logic fp);
    n = 0;
    while ((hi ? high_side_settle_flag : low_side_settle_flag) === 1'b1)
    begin
      n++;
      @(negedge aclk);
    end
    e = fp ? FAST_DELAY_CYC : SLOW;
    chk(32'(n >= e - 4 && n <= e + 2), 32'h1);
  endtask
  // One cycle trip on unit k, then count reset request pulses.
  task automatic pulse(input int k);
    @(posedge aclk);
    low_sup_trip <= (k == 0);
    low_mon_trip <= (k == 1);
    high_sup_trip <= (k == 2);
    high_mon_trip <= (k == 3);
    @(posedge aclk);
    {low_sup_trip, low_mon_trip, high_sup_trip, high_mon_trip} <= 4'h0;
    pc = 0;
    repeat (4)
    begin
      @(negedge aclk);
      pc += 32'(por_req);
    end
  endtask
  function automatic logic [1:0] sup_e(logic [6:0] c, logic dp);
    if (!c[SUP_EN] || (dp && !c[SUP_MODE])) return PERF_OFF;
    if (dp && c[AUTO_CTL]) return c[SUP_FP] ? PERF_NORMAL : PERF_OFF;
    return c[SUP_FP] ? PERF_FULL : PERF_NORMAL;
  endfunction
  function automatic logic [1:0] mon_e(logic [6:0] c, logic dp, logic hi);
    if (!c[MON_EN]) return PERF_OFF;
    if (dp && c[AUTO_CTL]) return (hi || !c[MON_FP]) ? PERF_OFF : PERF_NORMAL;
    return c[MON_FP] ? PERF_FULL : PERF_NORMAL;
  endfunction
  function automatic logic [7:0] st_e(logic dp);
    return {sup_e(lc, dp), mon_e(lc, dp, 1'b0), sup_e(hc, dp),
      mon_e(hc, dp, 1'b1)};
  endfunction
  // Main sequence.
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, wake_irq, isr_return, power_up_clear} = 4'h0;
    {low_sup_trip, low_mon_trip, high_sup_trip, high_mon_trip} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    ext_reset_n = 1'b1;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_LOW_CTRL);
    chk(rdat, 32'h9);
    rd(OFF_HIGH_CTRL);
    chk(rdat, 32'h9);
    rd(OFF_STATUS);
    chk(rdat, 32'h154);
    rd(8'h1C);
    chk(32'(resp_q), 32'(RESP_SLVERR));
    wr(8'h20, 32'h5);
    chk(32'(resp_q), 32'(RESP_SLVERR));
    for (int i = 0; i < 64; i++)
    begin
      lc = 7'(i);
      hc = 7'(i ^ 6'h2A);
      wr(OFF_LOW_CTRL, 32'(lc));
      settle(1'b0, lc[SUP_FP]);
      wr(OFF_HIGH_CTRL, 32'(hc));
      settle(1'b1, hc[SUP_FP]);
      chk({low_sup_state, low_mon_state, high_sup_state, high_mon_state},
        st_e(1'b0));
      chk(wake_fast, !(lc[0] && !lc[2]) && !(lc[3] && !lc[4]));
      wr(OFF_LPM, 32'h1);
      repeat (3) @(negedge aclk);
      chk({cpu_hold, power_mode}, {1'b1, PM_DEEP});
      chk({low_sup_state, low_mon_state, high_sup_state, high_mon_state},
        st_e(1'b1));
      e = wake_fast ? FAST_DELAY_CYC : SLOW;
      @(posedge aclk);
      wake_irq <= 1'b1;
      while (power_mode === PM_DEEP) @(negedge aclk);
      @(posedge aclk);
      wake_irq <= 1'b0;
      n = 1;
      while (power_mode === PM_WAKE)
      begin
        n++;
        @(negedge aclk);
      end
      chk(32'(n >= e - 2 && n <= e + 2), 32'h1);
      chk(power_mode, PM_ACTIVE);
    end
    rd(OFF_FLAGS);
    chk(rdat, 32'h10);
    chk(irq, 1'b0);
    wr(OFF_MASK, 32'h1F);
    chk(irq, 1'b1);
    wr(OFF_FLAGS, 32'h10);
    chk(irq, 1'b0);
    pulse(0);
    rd(OFF_FLAGS);
    chk({pc[3:0], rdat[27:0]}, {4'h0, 28'h1});
    chk(irq, 1'b1);
    wr(OFF_FLAGS, 32'h1);
    wr(OFF_CONFIG, 32'h1);
    pulse(1);
    rd(OFF_FLAGS);
    chk({pc[3:0], rdat[27:0]}, {4'h1, 28'h0});
    wr(OFF_HIGH_CTRL, 32'h49);
    settle(1'b1, 1'b0);
    pulse(3);
    rd(OFF_FLAGS);
    chk({pc[3:0], rdat[27:0]}, {4'h1, 28'h0});
    wr(OFF_LPM, 32'h2);
    repeat (2) @(negedge aclk);
    chk({cpu_hold, power_mode}, {1'b1, PM_LIGHT});
    @(posedge aclk);
    wake_irq <= 1'b1;
    @(posedge aclk);
    wake_irq <= 1'b0;
    @(negedge aclk);
    chk(power_mode, PM_ACTIVE);
    for (int j = 0; j < 2; j++)
    begin
      wr(OFF_LPM, j ? 32'h4 : 32'hC);
      @(posedge aclk);
      isr_return <= 1'b1;
      @(posedge aclk);
      isr_return <= 1'b0;
      repeat (2) @(negedge aclk);
      chk(power_mode, j ? PM_LIGHT : PM_DEEP);
      @(posedge aclk);
      ext_reset_n <= 1'(j);
      power_up_clear <= 1'(j);
      @(posedge aclk);
      ext_reset_n <= 1'b1;
      power_up_clear <= 1'b0;
      @(negedge aclk);
      chk({cpu_hold, power_mode}, {1'b0, PM_ACTIVE});
    end
    test_done();
  end
endmodule
